// ### design/flash_ctrl.sv
/*
 * Flash access and program/erase sequencer for a multi-module flash.
 * Assumes the core, the array and the command source all run on I_CLK;
 * the array returns read data on I_ARR_RDATA after the wait states.
 */
// Notes on behaviour
// - One sector or page erase finishes within 8.0 ms.
// - One page program finishes within 3.5 ms.
// - A module being read is not programmed or erased at once, except when a prefetch crosses into it in the cycle it accepts a command.
// - Idle modules may be programmed while reads use one other module.
// - Module 1 takes commands while the core reads module 0.
// - Wait states are paid in full on non-sequential reads and on sequential reads whose prefetch was skipped or dropped.
// - The read path prefetches the next word for sequential fetches.
// - A few sequencer cycles are added to each timed operation.
// - After reset nothing is protected and the array is left alone.
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int NUM_MODULES = 2,
    parameter int ADDR_W      = 16,
    parameter int DATA_W      = 16,
    parameter int WS_W        = 3,
    parameter int CNT_W       = 18,
    parameter int ER_CYC      = ER_CYCLES,
    parameter int PR_CYC      = PR_CYCLES
) (
    input  wire logic                   I_CLK,
    input  wire logic                   I_RST,
    input  wire logic [WS_W-1:0]        I_WAIT_STATES,
    input  wire logic                   I_RD_REQ,
    input  wire logic [ADDR_W-1:0]      I_RD_ADDR,
    output logic                        O_RD_READY,
    output logic                        O_RD_VALID,
    output logic [DATA_W-1:0]           O_RD_DATA,
    output logic                        O_ARR_RD_EN,
    output logic [ADDR_W-1:0]           O_ARR_ADDR,
    input  wire logic [DATA_W-1:0]      I_ARR_RDATA,
    input  wire logic [1:0]             I_READ_MODULES,
    input  wire logic                   I_PE_START,
    input  wire logic                   I_PE_ERASE,
    input  wire logic [$clog2(NUM_MODULES)-1:0] I_PE_MODULE,
    output logic                        O_PE_ACK,
    output logic [NUM_MODULES-1:0]      O_PE_BUSY,
    output logic [NUM_MODULES-1:0]      O_PE_DONE,
    output logic [NUM_MODULES-1:0]      O_PE_ERASE_ACT,
    output logic [NUM_MODULES-1:0]      O_PE_PROG_ACT,
    input  wire logic [NUM_MODULES-1:0] I_PROT_SET,
    output logic [NUM_MODULES-1:0]      O_PROT
);
    localparam int MOD_W = $clog2(NUM_MODULES);

    rd_state_t               rd_st_ff;
    logic [WS_W-1:0]         wait_ff;
    logic [ADDR_W-1:0]       arr_addr_ff;
    logic                    rd_valid_ff;
    logic [DATA_W-1:0]       rd_data_ff;
    logic                    pf_valid_ff;
    logic [ADDR_W-1:0]       pf_addr_ff;
    logic [DATA_W-1:0]       pf_data_ff;
    logic                    ack_ff;
    logic [WS_W-1:0]         ws_eff;
    logic [ADDR_W-1:0]       nxt_pf_addr;
    logic [MOD_W-1:0]        req_mod;
    logic [MOD_W-1:0]        acc_mod;
    logic                    take;
    logic                    hit;
    logic                    pf_allowed;
    logic [NUM_MODULES-1:0]  in_use;
    logic [NUM_MODULES-1:0]  start_ok;
    logic [NUM_MODULES-1:0]  pe_erase;
    int                      busy_cnt;
    int                      pe_limit;

    // Read side decode and flow control
    assign req_mod     = I_RD_ADDR[ADDR_W-1 -: MOD_W];
    assign acc_mod     = arr_addr_ff[ADDR_W-1 -: MOD_W];
    assign ws_eff      = (int'(I_WAIT_STATES) < MIN_WAIT_STATES) ?
                         WS_W'(MIN_WAIT_STATES) : I_WAIT_STATES;
    assign O_RD_READY  = (rd_st_ff == RD_IDLE) && !O_PE_BUSY[req_mod];
    assign take        = I_RD_REQ && O_RD_READY;
    assign hit         = pf_valid_ff && (I_RD_ADDR == pf_addr_ff);
    assign nxt_pf_addr = (rd_st_ff == RD_IDLE) ? I_RD_ADDR + 1'b1
                                               : arr_addr_ff + 1'b1;
    assign pf_allowed  = !O_PE_BUSY[nxt_pf_addr[ADDR_W-1 -: MOD_W]];
    assign O_ARR_RD_EN = (rd_st_ff != RD_IDLE);
    assign O_ARR_ADDR  = arr_addr_ff;
    assign O_RD_VALID  = rd_valid_ff;
    assign O_RD_DATA   = rd_data_ff;

    // Read sequencer: full wait states on a miss, prefetch after each served word unless the next word's module is busy
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rd_st_ff    <= RD_IDLE;
            wait_ff     <= '0;
            arr_addr_ff <= '0;
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
            pf_valid_ff <= 1'b0;
            pf_addr_ff  <= '0;
            pf_data_ff  <= '0;
        end else begin
            rd_valid_ff <= 1'b0;
            if (start_ok[pf_addr_ff[ADDR_W-1 -: MOD_W]]) begin
                pf_valid_ff <= 1'b0;
            end
            case (rd_st_ff)
                RD_IDLE: begin
                    if (take && hit) begin
                        rd_valid_ff <= 1'b1;
                        rd_data_ff  <= pf_data_ff;
                        pf_valid_ff <= 1'b0;
                        if (pf_allowed) begin
                            arr_addr_ff <= nxt_pf_addr;
                            wait_ff     <= ws_eff;
                            rd_st_ff    <= RD_PREFETCH;
                        end
                    end else if (take) begin
                        pf_valid_ff <= 1'b0;
                        arr_addr_ff <= I_RD_ADDR;
                        wait_ff     <= ws_eff;
                        rd_st_ff    <= RD_ACCESS;
                    end
                end
                RD_ACCESS: begin
                    if (wait_ff <= WS_W'(1)) begin
                        rd_valid_ff <= 1'b1;
                        rd_data_ff  <= I_ARR_RDATA;
                        if (pf_allowed) begin
                            arr_addr_ff <= nxt_pf_addr;
                            wait_ff     <= ws_eff;
                            rd_st_ff    <= RD_PREFETCH;
                        end else begin
                            rd_st_ff    <= RD_IDLE;
                        end
                    end else begin
                        wait_ff <= wait_ff - 1'b1;
                    end
                end
                RD_PREFETCH: begin
                    if (wait_ff <= WS_W'(1)) begin
                        pf_data_ff  <= I_ARR_RDATA;
                        pf_addr_ff  <= arr_addr_ff;
                        pf_valid_ff <= 1'b1;
                        rd_st_ff    <= RD_IDLE;
                    end else begin
                        wait_ff <= wait_ff - 1'b1;
                    end
                end
                default: rd_st_ff <= RD_IDLE;
            endcase
        end
    end

    // Modules touched by reads, parallel limit and command acceptance
    always_comb begin
        busy_cnt = $countones(O_PE_BUSY);
        pe_limit = (I_READ_MODULES <= 2'h1) ? PE_LIMIT_ONE_READ
                                            : PE_LIMIT_MULTI_READ;
        for (int m = 0; m < NUM_MODULES; m++) begin
            in_use[m]   = ((rd_st_ff != RD_IDLE) && (int'(acc_mod) == m)) ||
                          (I_RD_REQ && (int'(req_mod) == m));
            start_ok[m] = I_PE_START && (int'(I_PE_MODULE) == m) &&
                          !O_PE_BUSY[m] && !in_use[m] && !O_PROT[m] &&
                          (busy_cnt < pe_limit);
        end
    end

    // Acknowledge of an accepted command, one cycle after the request
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= |start_ok;
        end
    end
    assign O_PE_ACK = ack_ff;

    // One program/erase sequencer per module
    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
        pe_state_t          st_ff;
        logic [CNT_W-1:0]   cnt_ff;
        logic               erase_ff;
        logic               done_ff;
        logic               prot_ff;

        always_ff @(posedge I_CLK) begin
            if (I_RST) begin
                st_ff    <= PE_IDLE;
                cnt_ff   <= '0;
                erase_ff <= 1'b0;
                done_ff  <= 1'b0;
            end else begin
                done_ff <= 1'b0;
                case (st_ff)
                    PE_IDLE: begin
                        if (start_ok[g]) begin
                            st_ff    <= PE_SETUP;
                            cnt_ff   <= CNT_W'(PE_SETUP_CYCLES - 1);
                            erase_ff <= I_PE_ERASE;
                        end
                    end
                    PE_SETUP: begin
                        if (cnt_ff == '0) begin
                            st_ff  <= PE_RUN;
                            cnt_ff <= erase_ff ? CNT_W'(ER_CYC - 1)
                                               : CNT_W'(PR_CYC - 1);
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    PE_RUN: begin
                        if (cnt_ff == '0) begin
                            st_ff   <= PE_IDLE;
                            done_ff <= 1'b1;
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    default: st_ff <= PE_IDLE;
                endcase
            end
        end

        // Protection starts cleared and is only ever set
        always_ff @(posedge I_CLK) begin
            if (I_RST) begin
                prot_ff <= 1'b0;
            end else if (I_PROT_SET[g]) begin
                prot_ff <= 1'b1;
            end
        end

        assign O_PE_BUSY[g]      = (st_ff != PE_IDLE);
        assign O_PE_DONE[g]      = done_ff;
        assign O_PE_ERASE_ACT[g] = (st_ff == PE_RUN) && erase_ff;
        assign O_PE_PROG_ACT[g]  = (st_ff == PE_RUN) && !erase_ff;
        assign O_PROT[g]         = prot_ff;
        assign pe_erase[g]       = erase_ff;
    end

    // Busy length of module 0, read only by the checks below
    logic [CNT_W:0] len0_ff;
    always_ff @(posedge I_CLK) begin
        if (I_RST || !O_PE_BUSY[0]) begin
            len0_ff <= '0;
        end else begin
            len0_ff <= len0_ff + 1'b1;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    chk_read_not_busy: assert property (O_RD_VALID |-> !O_PE_BUSY[acc_mod])
        else $error("read served from a module under program or erase");
    chk_busy_refused: assert property (
        (I_PE_START && O_PE_BUSY[I_PE_MODULE]) |=> !O_PE_ACK)
        else $error("command accepted by a busy module");
    chk_parallel_limit: assert property (O_PE_ACK |-> $countones(O_PE_BUSY) <=
        (($past(I_READ_MODULES) <= 2'h1) ? PE_LIMIT_ONE_READ
                                         : PE_LIMIT_MULTI_READ))
        else $error("more busy modules than the read spread allows");
    chk_erase_length: assert property ((O_PE_DONE[0] && pe_erase[0]) |->
        (int'(len0_ff) == PE_SETUP_CYCLES + ER_CYC) &&
        (int'(len0_ff) <= ER_MAX_CYCLES))
        else $error("erase length wrong");
    chk_prog_length: assert property ((O_PE_DONE[0] && !pe_erase[0]) |->
        (int'(len0_ff) == PE_SETUP_CYCLES + PR_CYC) &&
        (int'(len0_ff) <= PR_MAX_CYCLES))
        else $error("program length wrong");
    chk_seq_hit_fast: assert property ((take && hit) |=> O_RD_VALID)
        else $error("prefetched word not served next cycle");
    chk_miss_waits: assert property ((take && !hit) |=> !O_RD_VALID [*1]
        ##0 (rd_st_ff == RD_ACCESS))
        else $error("miss served without wait states");
    chk_prefetch_runs: assert property (
        (O_RD_VALID && pf_allowed && rd_st_ff == RD_PREFETCH) |->
        O_ARR_ADDR == $past(O_ARR_ADDR) + 1'b1 || $past(take))
        else $error("prefetch not aimed at next word");
    chk_mod1_accepts: assert property ((I_PE_START && I_PE_MODULE == 1 &&
        O_PE_BUSY == '0 && !O_PROT[1] && !in_use[1] &&
        I_READ_MODULES <= 2'h1) |=> O_PE_ACK ##1 O_PE_BUSY[1])
        else $error("module 1 refused while reading module 0");
    chk_prot_clear: assert property ($past(I_RST) |-> O_PROT == '0)
        else $error("protection set after reset");

    cov_seq_hit:    cover property (take && hit);
    cov_erase_done: cover property (O_PE_DONE[0] && pe_erase[0]);
    cov_pe_refused: cover property (I_PE_START && O_PE_BUSY[I_PE_MODULE]);
    cov_pe_on_1:    cover property (O_PE_BUSY[1] && O_RD_VALID);
endmodule : flash_ctrl
`default_nettype wire

// ### design/flash_ctrl_pkg.sv
/*
 * Shared constants and types of the flash access and program controller.
 * Assumes a 25 MHz system clock; the erase and program cycle counts derive from it.
 */
package flash_ctrl_pkg;
    // System clock rate
    localparam int CLK_FREQ_MHZ        = 25;
    // Timed operation lengths (typical) and their upper bounds
    localparam int ER_TIME_US          = 7000;
    localparam int ER_MAX_US           = 8000;
    localparam int PR_TIME_US          = 3000;
    localparam int PR_MAX_US           = 3500;
    localparam int ER_CYCLES           = ER_TIME_US * CLK_FREQ_MHZ;
    localparam int PR_CYCLES           = PR_TIME_US * CLK_FREQ_MHZ;
    localparam int ER_MAX_CYCLES       = ER_MAX_US * CLK_FREQ_MHZ;
    localparam int PR_MAX_CYCLES       = PR_MAX_US * CLK_FREQ_MHZ;
    // Control sequencer overhead ahead of the timed phase
    localparam int PE_SETUP_CYCLES     = 4;
    // Parallel program/erase limits by read spread
    localparam int PE_LIMIT_ONE_READ   = 2;
    localparam int PE_LIMIT_MULTI_READ = 1;
    // Smallest wait-state count honoured on a non-sequential read
    localparam int MIN_WAIT_STATES     = 1;

    typedef enum logic [1:0] {RD_IDLE, RD_ACCESS, RD_PREFETCH} rd_state_t;
    typedef enum logic [1:0] {PE_IDLE, PE_SETUP, PE_RUN} pe_state_t;
endpackage : flash_ctrl_pkg

// ### tb/array_model.sv
/* Behavioural flash array behind the controller's array port.
   Assumes one clock; each word is its address mixed with a constant. */
`timescale 1ns/1ps
`default_nettype none
module array_model (
    input  wire logic        clk,
    input  wire logic        rd_en,
    input  wire logic [15:0] addr,
    output logic      [15:0] rdata
);
    logic [15:0] last_ff = 16'h0000;
    // Remember the last word so an idle bus can show its inverse
    always_ff @(posedge clk) begin
        last_ff <= rdata;
    end
    // Idle bus toggles each cycle; the last word shows again on every second idle cycle
    assign rdata = rd_en ? (addr ^ 16'h5a5a) : ~last_ff;
endmodule : array_model
`default_nettype wire

// ### tb/tb.sv
/* Self-checking bench for the flash access and program controller.
   Assumes a 25 MHz clock and shortened erase and program counts. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_ctrl_pkg::*;
    localparam int ER = 40;
    localparam int PR = 16;
    logic        I_CLK = 1'b0;
    logic        I_RST = 1'b1;
    logic [2:0]  I_WAIT_STATES = 3'h2;
    logic        I_RD_REQ = 1'b0;
    logic [15:0] I_RD_ADDR = 16'h0000;
    logic        O_RD_READY, O_RD_VALID, O_ARR_RD_EN, O_PE_ACK;
    logic [15:0] O_RD_DATA, O_ARR_ADDR, I_ARR_RDATA;
    logic [1:0]  I_READ_MODULES = 2'h1;
    logic        I_PE_START = 1'b0;
    logic        I_PE_ERASE = 1'b0;
    logic        I_PE_MODULE = 1'b0;
    logic [1:0]  O_PE_BUSY, O_PE_DONE, O_PE_ERASE_ACT, O_PE_PROG_ACT;
    logic [1:0]  O_PROT;
    logic [1:0]  I_PROT_SET = 2'h0;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    flash_ctrl #(.ER_CYC(ER), .PR_CYC(PR)) i_flash_ctrl (
        .I_CLK, .I_RST, .I_WAIT_STATES, .I_RD_REQ, .I_RD_ADDR,
        .O_RD_READY, .O_RD_VALID, .O_RD_DATA, .O_ARR_RD_EN, .O_ARR_ADDR,
        .I_ARR_RDATA, .I_READ_MODULES, .I_PE_START, .I_PE_ERASE,
        .I_PE_MODULE, .O_PE_ACK, .O_PE_BUSY, .O_PE_DONE, .O_PE_ERASE_ACT,
        .O_PE_PROG_ACT, .I_PROT_SET, .O_PROT
    );
    array_model i_array_model (.clk(I_CLK), .rd_en(O_ARR_RD_EN),
        .addr(O_ARR_ADDR), .rdata(I_ARR_RDATA));

    // Clock and hang guard
    initial begin
        forever #20 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // One read held until taken; latency counted in cycles to valid
    task automatic rd(input logic [15:0] a, input int lat);
        int n;
        n = 0;
        @(negedge I_CLK);
        I_RD_REQ = 1'b1;
        I_RD_ADDR = a;
        while (O_RD_READY !== 1'b1 && n < 100) begin
            @(negedge I_CLK);
            n++;
        end
        @(negedge I_CLK);
        I_RD_REQ = 1'b0;
        n = 1;
        while (O_RD_VALID !== 1'b1 && n < 20) begin
            @(negedge I_CLK);
            n++;
        end
        chk(n, lat);
        chk(O_RD_DATA, a ^ 16'h5a5a);
    endtask : rd

    // One-cycle program or erase command, then the acknowledge
    task automatic pe(input logic er, input logic m, input logic ack);
        @(negedge I_CLK);
        I_PE_START = 1'b1;
        I_PE_ERASE = er;
        I_PE_MODULE = m;
        @(negedge I_CLK);
        I_PE_START = 1'b0;
        chk(O_PE_ACK, ack);
    endtask : pe

    // Cycles from acknowledge to the done pulse of module m
    task automatic wait_done(input int m, input time t0, input int len);
        int n;
        n = 0;
        while (O_PE_DONE[m] !== 1'b1 && n < 500) begin
            @(negedge I_CLK);
            n++;
        end
        chk(32'(($time - t0) / 40), len);
    endtask : wait_done

    task automatic t_wait_states();
        for (int ws = 0; ws < 5; ws++) begin
            I_WAIT_STATES = ws[2:0];
            rd(16'h0100 + 16'(ws * 16),
               (ws < MIN_WAIT_STATES ? MIN_WAIT_STATES : ws) + 1);
        end
    endtask : t_wait_states

    task automatic t_prefetch();
        I_WAIT_STATES = 3'h3;
        rd(16'h0200, 4);
        rd(16'h0201, 1);
        rd(16'h0202, 1);
        rd(16'h0300, 4);
    endtask : t_prefetch

    // Erase module 1 while reading module 0, then program module 0
    task automatic t_parallel();
        time t0;
        time t1;
        I_WAIT_STATES = 3'h2;
        pe(1'b1, 1'b1, 1'b1);
        t0 = $time;
        pe(1'b1, 1'b1, 1'b0);
        rd(16'h0010, 3);
        repeat (4) @(negedge I_CLK);
        I_RD_ADDR = 16'h8000;
        I_RD_REQ = 1'b1;
        @(negedge I_CLK);
        chk(O_RD_READY, 1'b0);
        chk(O_PE_ERASE_ACT, 2'h2);
        I_RD_REQ = 1'b0;
        pe(1'b0, 1'b0, 1'b1);
        t1 = $time;
        chk(O_PE_BUSY, 2'h3);
        chk(O_PE_PROG_ACT, 2'h0);
        repeat (PE_SETUP_CYCLES) @(negedge I_CLK);
        chk(O_PE_PROG_ACT, 2'h1);
        wait_done(0, t1, PE_SETUP_CYCLES + PR);
        wait_done(1, t0, PE_SETUP_CYCLES + ER);
    endtask : t_parallel

    // Reads spread over two modules allow a single busy module
    task automatic t_limit();
        time t0;
        I_READ_MODULES = 2'h2;
        pe(1'b1, 1'b0, 1'b1);
        t0 = $time;
        pe(1'b0, 1'b1, 1'b0);
        wait_done(0, t0, PE_SETUP_CYCLES + ER);
        I_READ_MODULES = 2'h1;
    endtask : t_limit

    // Protected module refuses, the other one still programs
    task automatic t_prot();
        time t0;
        @(negedge I_CLK);
        I_PROT_SET = 2'h1;
        @(negedge I_CLK);
        I_PROT_SET = 2'h0;
        chk(O_PROT, 2'h1);
        pe(1'b0, 1'b0, 1'b0);
        pe(1'b0, 1'b1, 1'b1);
        t0 = $time;
        wait_done(1, t0, PE_SETUP_CYCLES + PR);
    endtask : t_prot

    // Main sequence
    initial begin
        repeat (20) @(negedge I_CLK);
        I_RST = 1'b0;
        chk(O_PROT, 2'h0);
        chk(O_PE_BUSY, 2'h0);
        t_wait_states();
        t_prefetch();
        t_parallel();
        t_limit();
        t_prot();
        close_out();
    end
endmodule : tb
`default_nettype wire
